// ### bench/sac_ana_model.sv
// Purpose: Analog side model, one held level of the selected channel for comparator
// Assumes: Input level of channel c is the code {c, 4'h9}
// Notes: Output toggles while powered down, so nothing can be sensed
module sac_ana_model (
  input wire logic mclk,
  input wire logic [3:0] chan_sel,
  input wire logic [1:0] ref_sel,
  input wire logic [7:0] dac_code,
  input wire logic sample,
  input wire logic adc_power,
  output logic cmp_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] held;
  logic tgl = 1'b0;
  always @(posedge mclk) tgl <= ~tgl;
  // Level is frozen once tracking stops
  always @(posedge mclk) if (sample) held <= {chan_sel, 4'h9};
  // Ground is the low end whatever the reference
  always_comb cmp_in = adc_power ? (held >= dac_code) : tgl;
endmodule : sac_ana_model

// ### bench/tb.sv
// Purpose: Self-checking bench for the converter sequencer
// Assumes: Zero wait state APB, analog model on the far side
// Notes: Durations get a wide window, poll reads add a few cycles
module tb;
  import sac_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RAT [8] = '{2, 8, 32, 5, 4, 16, 64, 5};
  logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic sleep = 0, rc_clk = 0, cmp_in;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, sample, adc_power, irq, wake, vector_req, e;
  logic [3:0] chan_sel;
  logic [1:0] ref_sel;
  logic [7:0] dac_code;
  int cyc = 0, nc, n_mismatch = 0, compares = 0;
  always #4 mclk = ~mclk;
  // Exactly five mclk periods, rising edges on mclk rising edges, still passed through the sync path
  always #20 rc_clk = ~rc_clk;
  always @(posedge mclk) cyc <= cyc + 1;
  sac_ctrl i_dut (.mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmp_in(cmp_in), .rc_clk(rc_clk),
    .sleep(sleep), .chan_sel(chan_sel), .ref_sel(ref_sel),
    .dac_code(dac_code), .sample(sample), .adc_power(adc_power),
    .irq(irq), .wake(wake), .vector_req(vector_req));
  sac_ana_model i_ana (.mclk(mclk), .chan_sel(chan_sel), .ref_sel(ref_sel),
    .dac_code(dac_code), .sample(sample), .adc_power(adc_power),
    .cmp_in(cmp_in));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task summarize;
    if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] g, input logic [31:0] x, input string m);
    compares++;
    if (g !== x) begin
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task conv(input logic [3:0] ch);
    int t0, k;
    apb(1, ADDR_CTRL0, {26'h0, ch, 2'b01});
    apb(1, ADDR_CTRL0, {26'h0, ch, 2'b11});
    t0 = cyc;
    k = 0;
    do begin
      apb(0, ADDR_CTRL0, 0);
      k++;
    end while (r[1] === 1'b1 && k < 400);
    nc = cyc - t0;
    chk(r[1], 0, "go never cleared");
    chk(k > 1, 1, "go not busy");
  endtask : conv
  task t_reset;
    logic [7:0] a [6];
    a = '{ADDR_CTRL0, ADDR_CTRL1, ADDR_RESULT, ADDR_FLAG, ADDR_INTC,
      ADDR_STATUS};
    foreach (a[i]) begin
      apb(0, a[i], 0);
      chk(r, 0, "reset value");
    end
    chk({dac_code, irq, wake, vector_req, adc_power, sample},
      {8'h00, 5'b00001}, "reset outputs");
  endtask : t_reset
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_unmapped;
    apb(1, 8'h18, 32'h3);
    apb(0, 8'h18, 0);
    chk(e, 1, "unmapped error");
    chk(r, 0, "unmapped read");
  endtask : t_unmapped
  task t_codes;
    for (int c = 0; c < 8; c++) begin
      apb(1, ADDR_CTRL1, {25'h0, c[2:0], 2'b00, 2'h2});
      conv(c[3:0]);
      chk(nc >= 10 * RAT[c] && nc <= 10 * RAT[c] + 20, 1,
        "time");
      // Fastest clock may outrun the comparator sync
      if (c != 0) begin
        apb(0, ADDR_RESULT, 0);
        chk(r, {24'h0, c[3:0], 4'h9}, "result");
      end
      apb(0, ADDR_FLAG, 0);
      chk({irq, r[0]}, 2'b01, "flag or irq");
      chk({chan_sel, ref_sel}, {c[3:0], 2'h2}, "selects");
      apb(1, ADDR_FLAG, 0);
    end
  endtask : t_codes
  task t_abort;
    apb(1, ADDR_CTRL1, {25'h0, 3'h6, 4'h0});
    apb(1, ADDR_CTRL0, {26'h0, 4'h5, 2'b01});
    apb(1, ADDR_CTRL0, {26'h0, 4'h5, 2'b11});
    repeat (256) @(posedge mclk);
    apb(1, ADDR_CTRL0, {26'h0, 4'h5, 2'b01});
    apb(0, ADDR_RESULT, 0);
    chk(r, 32'h79, "result kept");
    apb(0, ADDR_STATUS, 0);
    chk(r[3:0], 0, "partial bits");
    apb(0, ADDR_FLAG, 0);
    chk(r[0], 0, "abort flag");
  endtask : t_abort
  task t_irq;
    apb(1, ADDR_FLAG, 32'h2);
    apb(1, ADDR_INTC, 32'h0);
    apb(1, ADDR_CTRL1, {25'h0, 3'h4, 4'h0});
    conv(4'h1);
    repeat (2) @(posedge mclk);
    chk({irq, vector_req}, 2'b10, "irq no vector");
    apb(1, ADDR_INTC, 32'h3);
    repeat (2) @(posedge mclk);
    chk(vector_req, 1, "vector");
    apb(1, ADDR_INTC, 32'h1);
    repeat (2) @(posedge mclk);
    chk(vector_req, 0, "peripheral_irq_enable only");
    apb(1, ADDR_FLAG, 32'h2);
    repeat (2) @(posedge mclk);
    chk(irq, 0, "irq cleared");
  endtask : t_irq
  task t_sleep;
    int k;
    apb(1, ADDR_CTRL1, {25'h0, 3'h6, 4'h0});
    apb(1, ADDR_CTRL0, {26'h0, 4'h2, 2'b01});
    apb(1, ADDR_CTRL0, {26'h0, 4'h2, 2'b11});
    repeat (100) @(posedge mclk);
    sleep <= 1;
    repeat (4) @(posedge mclk);
    chk(adc_power, 0, "sleep power");
    apb(0, ADDR_CTRL0, 0);
    chk(r[1:0], 2'b01, "sleep abort");
    sleep <= 0;
    apb(1, ADDR_CTRL1, {25'h0, 3'h3, 4'h0});
    apb(1, ADDR_CTRL0, {26'h0, 4'h2, 2'b11});
    sleep <= 1;
    k = 0;
    while (wake !== 1'b1 && k < 200) begin
      @(posedge mclk);
      k++;
    end
    chk(wake, 1, "rc wake");
    sleep <= 0;
    apb(0, ADDR_RESULT, 0);
    chk(r, 32'h29, "sleep result");
    apb(1, ADDR_FLAG, 32'h2);
  endtask : t_sleep
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 0;
    t_reset();
    t_unmapped();
    t_codes();
    t_abort();
    t_irq();
    t_sleep();
    apb(1, ADDR_CTRL0, {26'h0, 4'h2, 2'b11});
    // Reset lands mid-conversion; the late flag read proves it was dropped
    repeat (20) @(posedge mclk);
    rst <= 1;
    repeat (3) @(posedge mclk);
    rst <= 0;
    repeat (80) @(posedge mclk);
    t_reset();
    summarize();
  end
  initial begin
    repeat (30000) @(posedge mclk);
    n_mismatch++;
    summarize();
  end
endmodule : tb

// ### verilog/sac_ctrl.sv
// Purpose: APB controlled 8-bit successive approximation sequencer
// Assumes: Comparator and RC clock arrive asynchronously on pins
// Notes: One bit period is one tick of the selected conversion clock
module sac_ctrl import sac_pkg::*; #(
  parameter logic [7:0] INSTR_WAIT = INSTR_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmp_in,
  input wire logic rc_clk,
  input wire logic sleep,
  output logic [3:0] chan_sel,
  output logic [1:0] ref_sel,
  output logic [7:0] dac_code,
  output logic sample,
  output logic adc_power,
  output logic irq,
  output logic wake,
  output logic vector_req
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic on;
    logic go;
    logic [3:0] chan;
    logic [1:0] refs;
    logic [2:0] csel;
    logic flag;
    logic ie;
    logic global_irq_enable;
    logic peripheral_irq_enable;
    logic [7:0] result;
    logic [7:0] sar;
    logic [7:0] dac;
    sac_state_t st;
    logic [3:0] bit_conversion_period;
    logic [7:0] wcnt;
    logic sleep_off;
    logic power;
    logic sample;
    logic irq;
    logic wake;
    logic vec;
    logic rc_prev;
  } sac_ctrl_t;
  sac_ctrl_t s, next_s;

  logic [1:0] sync_q;
  logic cmp_s;
  logic rc_s;
  logic rc_rise;
  logic tick;
  logic setup;
  logic wr;
  logic start;
  logic abort;
  logic done;
  logic rc_mode;
  logic [2:0] bitn;

  function automatic logic mapped(input logic [7:0] a);
    return a == ADDR_CTRL0 || a == ADDR_CTRL1 || a == ADDR_RESULT ||
      a == ADDR_FLAG || a == ADDR_INTC || a == ADDR_STATUS;
  endfunction : mapped

  sac_sync #(.W(2)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .d({rc_clk, cmp_in}),
    .q(sync_q)
  );
  assign cmp_s = sync_q[0];
  assign rc_s = sync_q[1];
  assign rc_rise = rc_s && !s.rc_prev;

  sac_div u_div (
    .mclk(mclk),
    .rst(rst),
    .run(s.st == ST_CONV),
    .sel(s.csel),
    .rc_rise(rc_rise),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // Bus and sequencer
  // ----------------------------------------------------------------
  assign setup = psel && !penable;
  assign wr = psel && penable && s.pready && pwrite;
  assign rc_mode = sac_is_rc(s.csel);
  assign bitn = 3'(4'h8 - s.bit_conversion_period);
  assign done = s.st == ST_CONV && tick && s.bit_conversion_period == TAD_LAST;
  // Start needs the converter already on before this write
  assign start = wr && paddr == ADDR_CTRL0 && pwdata[CTRL0_GO] &&
    !s.go && s.on && pwdata[CTRL0_ON];
  assign abort = s.go && ((wr && paddr == ADDR_CTRL0 &&
    (!pwdata[CTRL0_GO] || !pwdata[CTRL0_ON])) ||
    (sleep && !rc_mode));

  always_comb begin
    next_s = s;
    next_s.pready = 1'b1;
    next_s.rc_prev = rc_s;
    if (setup) begin
      next_s.pslverr = !mapped(paddr);
      next_s.prdata = 32'h00000000;
      if (paddr == ADDR_CTRL0) begin
        next_s.prdata[CTRL0_ON] = s.on;
        next_s.prdata[CTRL0_GO] = s.go;
        next_s.prdata[CTRL0_CHAN +: 4] = s.chan;
      end else if (paddr == ADDR_CTRL1) begin
        next_s.prdata[CTRL1_REF +: 2] = s.refs;
        next_s.prdata[CTRL1_CSEL +: 3] = s.csel;
      end else if (paddr == ADDR_RESULT) begin
        next_s.prdata[7:0] = s.result;
      end else if (paddr == ADDR_FLAG) begin
        next_s.prdata[FLAG_DONE] = s.flag;
        next_s.prdata[FLAG_IE] = s.ie;
      end else if (paddr == ADDR_INTC) begin
        next_s.prdata[INTC_PERIPHERAL_IRQ_ENABLE] = s.peripheral_irq_enable;
        next_s.prdata[INTC_GIE] = s.global_irq_enable;
      end else if (paddr == ADDR_STATUS) begin
        next_s.prdata[7:0] = s.sar;
      end
    end
    if (wr) begin
      if (paddr == ADDR_CTRL0) begin
        next_s.on = pwdata[CTRL0_ON];
        next_s.chan = pwdata[CTRL0_CHAN +: 4];
      end else if (paddr == ADDR_CTRL1) begin
        next_s.refs = pwdata[CTRL1_REF +: 2];
        next_s.csel = pwdata[CTRL1_CSEL +: 3];
      end else if (paddr == ADDR_FLAG) begin
        if (!pwdata[FLAG_DONE]) begin
          next_s.flag = 1'b0;
        end
        next_s.ie = pwdata[FLAG_IE];
      end else if (paddr == ADDR_INTC) begin
        next_s.peripheral_irq_enable = pwdata[INTC_PERIPHERAL_IRQ_ENABLE];
        next_s.global_irq_enable = pwdata[INTC_GIE];
      end
    end
    case (s.st)
      ST_IDLE: begin
        if (start) begin
          next_s.go = 1'b1;
          next_s.sar = 8'h00;
          next_s.dac = SAR_FIRST_TRIAL;
          next_s.bit_conversion_period = 4'h0;
          next_s.wcnt = INSTR_WAIT;
          // RC start is held back so a sleep can slip in first
          next_s.st = rc_mode ? ST_WAIT : ST_CONV;
        end
      end
      ST_WAIT: begin
        if (abort) begin
          next_s.go = 1'b0;
          next_s.st = ST_IDLE;
        end else if (s.wcnt <= 8'h01) begin
          next_s.st = ST_CONV;
        end else begin
          next_s.wcnt = s.wcnt - 8'h01;
        end
      end
      ST_CONV: begin
        if (abort) begin
          // Partial value stays in sar, result untouched
          next_s.go = 1'b0;
          next_s.sample = 1'b1;
          next_s.st = ST_IDLE;
        end else if (done) begin
          next_s.result = s.sar;
          next_s.go = 1'b0;
          next_s.flag = 1'b1;
          next_s.sample = 1'b1;
          next_s.dac = 8'h00;
          next_s.st = ST_IDLE;
          if (sleep && !s.ie) begin
            next_s.sleep_off = 1'b1;
          end
        end else if (tick) begin
          next_s.bit_conversion_period = s.bit_conversion_period + 4'h1;
          if (s.bit_conversion_period == 4'h0) begin
            next_s.sample = 1'b0;
          end else if (s.bit_conversion_period <= 4'h8) begin
            next_s.sar[bitn] = cmp_s;
            next_s.dac = next_s.sar;
            if (bitn != 3'h0) begin
              next_s.dac[bitn - 3'h1] = 1'b1;
            end
          end
        end
      end
      default: begin
        next_s.st = ST_IDLE;
      end
    endcase
    if (!sleep) begin
      next_s.sleep_off = 1'b0;
    end else if (!rc_mode) begin
      next_s.sleep_off = 1'b1;
    end
    next_s.power = next_s.on && !next_s.sleep_off;
    next_s.irq = next_s.flag && next_s.ie;
    next_s.wake = next_s.irq && sleep;
    // Vector only with both enables; otherwise execution resumes inline
    next_s.vec = next_s.irq && next_s.global_irq_enable && next_s.peripheral_irq_enable;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.chan <= RST_CHAN;
      s.refs <= RST_REF;
      s.csel <= RST_CSEL;
      s.result <= RST_RESULT;
      s.sample <= 1'b1;
      s.st <= ST_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign chan_sel = s.chan;
  assign ref_sel = s.refs;
  assign dac_code = s.dac;
  assign sample = s.sample;
  assign adc_power = s.power;
  assign irq = s.irq;
  assign wake = s.wake;
  assign vector_req = s.vec;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  logic [4:0] tick_cnt;
  logic [7:0] gap;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tick_cnt <= 5'h00;
      gap <= 8'h00;
    end else begin
      tick_cnt <= start ? 5'h00 : tick_cnt + 5'(tick);
      gap <= (tick || s.st != ST_CONV) ? 8'h00 : gap + 8'h01;
    end
  end

  sequence s_done;
    done && !abort;
  endsequence
  sequence s_finished;
    !s.go && s.flag && s.st == ST_IDLE;
  endsequence

  chk_done_load: assert property (s_done |=> s_finished ##0
    s.result == $past(s.sar)) else $error("completion did not load");
  chk_flag_any_ie: assert property (s_done |=> s.flag)
    else $error("done flag not set");
  chk_ten_periods: assert property (s_done |-> tick_cnt == 5'h09)
    else $error("conversion not ten bit periods");
  chk_div_ratio: assert property (
    tick && !rc_mode && tick_cnt != 5'h00
    |-> gap + 8'h01 == 8'(sac_ratio(s.csel)))
    else $error("bit period length wrong");
  chk_abort_keep: assert property (abort && s.st == ST_CONV
    |=> s.result == $past(s.result) && !s.go)
    else $error("abort changed result");
  chk_unresolved: assert property (s.st == ST_CONV && s.bit_conversion_period >= 4'h1
    |-> (s.sar & (8'hff >> (s.bit_conversion_period - 4'h1))) == 8'h00)
    else $error("unresolved bits not zero");
  chk_go_busy: assert property (s.st != ST_IDLE |-> s.go)
    else $error("go low while busy");
  chk_irq_flag: assert property (s.flag && s.ie [*2] |-> irq)
    else $error("interrupt missing");
  chk_rc_wait: assert property (start && rc_mode
    |=> s.st == ST_WAIT ##1 s.st != ST_IDLE || $past(abort))
    else $error("rc start not delayed");
  chk_sleep_abort: assert property (
    sleep && !rc_mode && s.st != ST_IDLE
    |=> s.st == ST_IDLE && !adc_power && s.on == $past(s.on))
    else $error("sleep did not abort");
  chk_vector_en: assert property (vector_req |-> s.global_irq_enable && s.peripheral_irq_enable)
    else $error("vector without enables");
  chk_power_on: assert property (adc_power |-> s.on)
    else $error("powered while off");
  chk_go_needs_on: assert property (!s.on |-> !s.go)
    else $error("go set while converter off");
  // Flag falls only by a software write
  chk_flag_sticky: assert property (
    s.flag && !(wr && paddr == ADDR_FLAG) |=> s.flag)
    else $error("flag dropped by hardware");
  // No write means flag and enable stay, so wake must follow
  chk_wake_sleep: assert property (
    irq && sleep && !wr |=> wake)
    else $error("no wake from sleep");
  chk_result_hold: assert property (
    !done |=> $stable(s.result))
    else $error("result changed without completion");
  chk_sample_held: assert property (
    s.st == ST_CONV && s.bit_conversion_period != 4'h0 |-> !sample)
    else $error("sample-hold tracking in conversion");
endmodule : sac_ctrl

// ### verilog/sac_div.sv
// Purpose: Bit period tick from a divided mclk or the RC oscillator
// Assumes: rc_rise is a one-cycle pulse on each RC rising edge
// Notes: Counter restarts whenever run is low
module sac_div import sac_pkg::*; (
  input wire logic mclk,
  input wire logic rst,
  input wire logic run,
  input wire logic [2:0] sel,
  input wire logic rc_rise,
  output logic tick
);
  typedef struct packed {
    logic [6:0] cnt;
    logic tick;
  } sac_div_t;
  sac_div_t s, next_s;
  logic [6:0] ratio;

  always_comb begin
    ratio = sac_ratio(sel);
    next_s = s;
    next_s.tick = 1'b0;
    if (!run) begin
      next_s.cnt = 7'h00;
    end else if (sac_is_rc(sel)) begin
      next_s.tick = rc_rise;
    end else if (s.cnt == ratio - 7'h01) begin
      next_s.cnt = 7'h00;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 7'h01;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;
endmodule : sac_div

// ### verilog/sac_pkg.sv
// Purpose: Shared constants for the converter control block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Byte addresses below are word aligned
package sac_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] ADDR_RESULT = 8'h08;
  localparam logic [7:0] ADDR_FLAG = 8'h0c;
  localparam logic [7:0] ADDR_INTC = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL0_ON = 0;
  localparam int CTRL0_GO = 1;
  localparam int CTRL0_CHAN = 2;
  localparam int CTRL1_REF = 0;
  localparam int CTRL1_CSEL = 4;
  localparam int FLAG_DONE = 0;
  localparam int FLAG_IE = 1;
  localparam int INTC_PERIPHERAL_IRQ_ENABLE = 0;
  localparam int INTC_GIE = 1;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] RST_CHAN = 4'h0;
  localparam logic [1:0] RST_REF = 2'h0;
  localparam logic [2:0] RST_CSEL = 3'h0;
  localparam logic [7:0] RST_RESULT = 8'h00;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam logic [3:0] CONV_TADS = 4'ha;
  localparam logic [3:0] TAD_LAST = 4'h9;
  localparam logic [7:0] INSTR_CYCLES = 8'h04;
  localparam logic [7:0] SAR_FIRST_TRIAL = 8'h80;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CONV} sac_state_t;

  // Divide ratio of a clock select code, zero for the RC source
  function automatic logic [6:0] sac_ratio(input logic [2:0] sel);
    logic [6:0] r;
    r = 7'h00;
    case (sel)
      3'h0: r = 7'h02;
      3'h4: r = 7'h04;
      3'h1: r = 7'h08;
      3'h5: r = 7'h10;
      3'h2: r = 7'h20;
      3'h6: r = 7'h40;
      default: r = 7'h00;
    endcase
    return r;
  endfunction : sac_ratio

  function automatic logic sac_is_rc(input logic [2:0] sel);
    return sel[1:0] == 2'h3;
  endfunction : sac_is_rc
endpackage : sac_pkg

// ### verilog/sac_sync.sv
// Purpose: Two-flop synchroniser for levels from outside the clock
// Assumes: Inputs change slowly compared with mclk
// Notes: First stage is read only by the second
module sac_sync #(
  parameter int W = 2
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } sac_sync_t;
  sac_sync_t s, next_s;

  always_comb begin
    next_s.meta = d;
    next_s.q = s.meta;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.q;
endmodule : sac_sync
